// >>> core/energy_sense_params.svh
// offsets, field positions, reset values and timing counts of the energy-sense block
`ifndef ENERGY_SENSE_PARAMS_SVH
`define ENERGY_SENSE_PARAMS_SVH
`define ES_CTRL_IDX        8'h1d
`define ES_CTRL_ADDR       12'h074
`define ES_IRQ_STAT_ADDR   12'h080
`define ES_IRQ_EN_ADDR     12'h084
`define ES_IRQ_CLR_ADDR    12'h088
`define ES_BIT_ENABLE      15
`define ES_BIT_AUTO_WAKE   14
`define ES_BIT_AUTO_SLEEP  13
`define ES_BIT_MANUAL      12
`define ES_BIT_SINGLE      11
`define ES_BIT_POWER       10
`define ES_BIT_NOISE_HIT   9
`define ES_BIT_ACT_HIT     8
`define ES_NOISE_LSB       4
`define ES_ACT_LSB         0
`define ES_RST_AUTO_WAKE   1'b1
`define ES_RST_AUTO_SLEEP  1'b1
`define ES_RST_LIMIT       4'h1
`define ES_BURST_PULSES    3'h4
`define ES_CLK_HZ          50000000
`define ES_IDLE_MS         2000
`define ES_IDLE_CYCLES     ((`ES_CLK_HZ / 1000) * `ES_IDLE_MS)
`endif

// >>> core/energy_sense_pkg.sv
// types of the energy-sense power control block
package energy_sense_pkg;
   typedef enum logic [1:0] {
      PWR_DOWN,
      PWR_UP,
      PWR_BURST
   } power_e;
endpackage : energy_sense_pkg

// >>> core/energy_detect_power_control.sv
// energy-sense power control with apb register slave and interrupt
`timescale 1ns/1ns
`include "energy_sense_params.svh"

// Behaviour
// R1: bit 15 enables energy-sense power saving
// R2: software disables crossover when autoneg off
// R3: auto wake when data count reaches limit
// R4: auto sleep when no line energy
// R5: manual bit toggles power state immediately
// R6: software toggles after clearing interrupt
// R7: four pulses per wake, one if disabled
// R8: bit 10 shows current power state
// R9: bit 9 noise hit, clear on read
// R10: bit 8 activity hit, clear on read
// R11: bits 7:4 noise event limit
// R12: bits 3:0 activity event limit
// R13: counters clear after 2 s idle
// R14: masked power change raises interrupt; here it only sets irq_stat, energy_sense_irq_o waits for irq_en
// R15: manual bit self-clears, reads zero
module energy_detect_power_control #(
   parameter int IDLE_CYCLES = `ES_IDLE_CYCLES,
   parameter int CNT_W       = 28
) (
   input  wire logic        sys_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        data_event_i,
   input  wire logic        error_event_i,
   input  wire logic        energy_sensed_i,
   output logic             line_driver_on_o,
   output logic             pulse_o,
   output logic             energy_sense_irq_o
);

   initial begin
      if (IDLE_CYCLES < 2 || IDLE_CYCLES >= (1 << CNT_W)) begin
         $error("IDLE_CYCLES does not fit the idle counter");
      end
   end

   typedef struct packed {
      logic                             enable;
      logic                             auto_wake;
      logic                             auto_sleep;
      logic                             single_pulse_only;
      logic                             noise_limit_hit;
      logic                             activity_limit_hit;
      logic [3:0]                       noise_limit;
      logic [3:0]                       activity_limit;
      logic [3:0]                       data_cnt;
      logic [3:0]                       err_cnt;
      logic [CNT_W-1:0]                 idle_cnt;
      energy_sense_pkg::power_e         pstate;
      logic [2:0]                       pulses_left;
      logic                             pulse_gap;
      logic                             irq_stat;
      logic                             irq_en;
      logic [31:0]                      prdata;
      logic                             pready;
      logic                             pslverr;
      logic                             driver_on;
      logic                             pulse;
      logic                             irq;
   } state_s;

   state_s st_q;
   state_s st_d;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] want);
      hit = (a == want);
   endfunction : hit

   logic        setup;
   logic        acc;
   logic        wr;
   logic        rd;
   logic        man_req;
   logic        wake;
   logic        sleep;
   logic        powered;
   logic [15:0] ctrl_view;

   always_comb begin
      setup   = psel_i && !penable_i;
      // writes and clear-on-read land at the access edge, where the master samples pready
      acc     = psel_i && penable_i && st_q.pready;
      wr      = acc && pwrite_i;
      rd      = setup && !pwrite_i;
      powered = (st_q.pstate != energy_sense_pkg::PWR_DOWN);
      ctrl_view = 16'h0000;
      ctrl_view[`ES_BIT_ENABLE]     = st_q.enable;
      ctrl_view[`ES_BIT_AUTO_WAKE]  = st_q.auto_wake;
      ctrl_view[`ES_BIT_AUTO_SLEEP] = st_q.auto_sleep;
      ctrl_view[`ES_BIT_SINGLE]     = st_q.single_pulse_only;
      ctrl_view[`ES_BIT_POWER]      = powered;
      ctrl_view[`ES_BIT_NOISE_HIT]  = st_q.noise_limit_hit;
      ctrl_view[`ES_BIT_ACT_HIT]    = st_q.activity_limit_hit;
      ctrl_view[`ES_NOISE_LSB +: 4] = st_q.noise_limit;
      ctrl_view[`ES_ACT_LSB +: 4]   = st_q.activity_limit;
      // R5: manual toggle request
      man_req = wr && hit(paddr_i, `ES_CTRL_ADDR) && pstrb_i[1] && pwdata_i[`ES_BIT_MANUAL];
      // R3: auto wake on activity
      wake  = st_q.auto_wake && !powered && (st_q.data_cnt >= st_q.activity_limit);
      // R4: auto sleep on silence
      sleep = st_q.auto_sleep && powered && !energy_sensed_i;

      st_d         = st_q;
      st_d.pulse   = 1'b0;
      st_d.pready  = setup;
      st_d.pslverr = 1'b0;
      // read data stands only in the answer cycle
      st_d.prdata  = 32'h0000_0000;

      // R13: idle timeout clears counters
      if (data_event_i) begin
         st_d.idle_cnt = '0;
      end else if (st_q.idle_cnt == CNT_W'(IDLE_CYCLES - 1)) begin
         st_d.idle_cnt = '0;
         st_d.data_cnt = 4'h0;
         st_d.err_cnt  = 4'h0;
      end else begin
         st_d.idle_cnt = st_q.idle_cnt + CNT_W'(1);
      end
      if (data_event_i && st_q.data_cnt != 4'hf) begin
         st_d.data_cnt = st_q.data_cnt + 4'h1;
      end
      if (error_event_i && st_q.err_cnt != 4'hf) begin
         st_d.err_cnt = st_q.err_cnt + 4'h1;
      end

      if (setup) begin
         if (hit(paddr_i, `ES_CTRL_ADDR)) begin
            // R15: manual bit reads zero
            st_d.prdata = {16'h0000, ctrl_view};
         end else if (hit(paddr_i, `ES_IRQ_STAT_ADDR)) begin
            st_d.prdata = {31'h0, st_q.irq_stat};
         end else if (hit(paddr_i, `ES_IRQ_EN_ADDR)) begin
            st_d.prdata = {31'h0, st_q.irq_en};
         end else if (!hit(paddr_i, `ES_IRQ_CLR_ADDR)) begin
            st_d.pslverr = 1'b1;
         end
         if (!rd) begin
            st_d.prdata = 32'h0000_0000;
         end
      end
      if (acc && hit(paddr_i, `ES_CTRL_ADDR)) begin
         if (pwrite_i) begin
            // R1: enable write
            if (pstrb_i[1]) begin
               st_d.enable            = pwdata_i[`ES_BIT_ENABLE];
               st_d.auto_wake         = pwdata_i[`ES_BIT_AUTO_WAKE];
               st_d.auto_sleep        = pwdata_i[`ES_BIT_AUTO_SLEEP];
               st_d.single_pulse_only = pwdata_i[`ES_BIT_SINGLE];
            end
            // R11: noise limit field
            // R12: activity limit field
            if (pstrb_i[0]) begin
               st_d.noise_limit    = pwdata_i[`ES_NOISE_LSB +: 4];
               st_d.activity_limit = pwdata_i[`ES_ACT_LSB +: 4];
            end
         end else begin
            // R9: noise hit clear on read
            st_d.noise_limit_hit    = 1'b0;
            // R10: activity hit clear on read
            st_d.activity_limit_hit = 1'b0;
         end
      end
      if (wr && hit(paddr_i, `ES_IRQ_EN_ADDR) && pstrb_i[0]) begin
         st_d.irq_en = pwdata_i[0];
      end
      if (wr && hit(paddr_i, `ES_IRQ_CLR_ADDR) && pstrb_i[0] && pwdata_i[0]) begin
         st_d.irq_stat = 1'b0;
      end

      // R9: noise limit reached, no power action
      if (st_q.err_cnt >= st_q.noise_limit && st_q.noise_limit != 4'h0) begin
         st_d.noise_limit_hit = 1'b1;
      end
      // R10: activity limit reached; set beats read clear
      if (st_q.data_cnt >= st_q.activity_limit && st_q.activity_limit != 4'h0) begin
         st_d.activity_limit_hit = 1'b1;
      end

      // R1: state machine runs only while enabled
      if (!st_q.enable) begin
         st_d.pstate      = energy_sense_pkg::PWR_UP;
         st_d.pulses_left = 3'h0;
      end else begin
         case (st_q.pstate)
            energy_sense_pkg::PWR_DOWN: begin
               if (man_req || wake) begin
                  // R7: burst length on wake
                  st_d.pstate      = energy_sense_pkg::PWR_BURST;
                  st_d.pulses_left = st_q.single_pulse_only ? 3'h1 : `ES_BURST_PULSES;
                  st_d.pulse_gap   = 1'b0;
                  st_d.data_cnt    = 4'h0;
               end
            end
            energy_sense_pkg::PWR_BURST: begin
               if (man_req) begin
                  st_d.pstate = energy_sense_pkg::PWR_DOWN;
               end else if (st_q.pulses_left == 3'h0) begin
                  st_d.pstate = energy_sense_pkg::PWR_UP;
               end else begin
                  // R7: one pulse every other cycle
                  st_d.pulse_gap = !st_q.pulse_gap;
                  if (!st_q.pulse_gap) begin
                     st_d.pulse       = 1'b1;
                     st_d.pulses_left = st_q.pulses_left - 3'h1;
                  end
               end
            end
            energy_sense_pkg::PWR_UP: begin
               if (man_req || sleep) begin
                  st_d.pstate = energy_sense_pkg::PWR_DOWN;
               end
            end
            default: begin
               st_d.pstate = energy_sense_pkg::PWR_UP;
            end
         endcase
      end

      // R14: power change while enabled sets status, set wins clear
      if (st_q.enable && (st_d.pstate == energy_sense_pkg::PWR_DOWN) != !powered) begin
         st_d.irq_stat = 1'b1;
      end
      st_d.driver_on = (st_d.pstate != energy_sense_pkg::PWR_DOWN);
      st_d.irq       = st_d.irq_stat && st_d.irq_en;
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         st_q                   <= '0;
         st_q.auto_wake         <= `ES_RST_AUTO_WAKE;
         st_q.auto_sleep        <= `ES_RST_AUTO_SLEEP;
         st_q.noise_limit       <= `ES_RST_LIMIT;
         st_q.activity_limit    <= `ES_RST_LIMIT;
         st_q.pstate            <= energy_sense_pkg::PWR_UP;
         st_q.driver_on         <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign prdata_o           = st_q.prdata;
   assign pready_o           = st_q.pready;
   assign pslverr_o          = st_q.pslverr;
   assign line_driver_on_o   = st_q.driver_on;
   assign pulse_o            = st_q.pulse;
   assign energy_sense_irq_o = st_q.irq;

endmodule : energy_detect_power_control

// >>> dv/energy_sense_properties.sv
// apb and line-side assertions of the energy-sense block
`timescale 1ns/1ns
module energy_sense_properties (
   input wire logic        sys_clk_i,
   input wire logic        sys_rst_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        line_driver_on_o,
   input wire logic        pulse_o,
   input wire logic        energy_sense_irq_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   answer_next_a: assert property (psel_i && !penable_i |=> pready_o)
      else $error("no answer after setup");
   answer_once_a: assert property (pready_o |=> !pready_o)
      else $error("answer held too long");
   idle_zero_a: assert property (!pready_o |-> prdata_o == 32'h0)
      else $error("read data outside answer");
   upper_zero_a: assert property (pready_o |-> prdata_o[31:16] == 16'h0)
      else $error("upper read data set");
   manual_zero_a: assert property (pready_o && paddr_i == 12'h074 |-> !prdata_o[12])
      else $error("manual bit reads one");
   unmapped_err_a: assert property (pready_o && paddr_i == 12'h100 |-> pslverr_o)
      else $error("unmapped access accepted");
   pulse_gap_a: assert property (pulse_o |=> !pulse_o)
      else $error("pulses back to back");
   pulse_power_a: assert property (pulse_o |-> line_driver_on_o)
      else $error("pulse while powered down");
   cover property (energy_sense_irq_o);
   cover property (pulse_o);
   cover property (pslverr_o);
endmodule : energy_sense_properties
bind energy_detect_power_control energy_sense_properties u_props (
   .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
   .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .line_driver_on_o(line_driver_on_o), .pulse_o(pulse_o),
   .energy_sense_irq_o(energy_sense_irq_o));

// >>> dv/link_partner.sv
// cable partner driving line energy and event pulses
`timescale 1ns/1ns
module link_partner (
   input  wire logic clk_i,
   output logic      data_o,
   output logic      err_o,
   output logic      energy_o
);
   initial begin
      data_o = 1'b0;
      err_o = 1'b0;
      energy_o = 1'b0;
   end
   task automatic sense(input logic v);
      @(posedge clk_i);
      energy_o <= v;
   endtask : sense
   // a quiet cycle between events keeps each one countable
   task automatic send(input logic noise, input int n);
      repeat (n) begin
         @(posedge clk_i);
         if (noise) err_o <= 1'b1;
         else data_o <= 1'b1;
         @(posedge clk_i);
         err_o <= 1'b0;
         data_o <= 1'b0;
      end
   endtask : send
endmodule : link_partner

// >>> dv/tb_energy_detect_power_control.sv
// self-checking bench of the energy-sense power control block
`timescale 1ns/1ns
module tb_energy_detect_power_control;
   logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, re;
   logic [11:0] pa = 0;
   logic [31:0] pwd = 0, prd, rd;
   logic [3:0]  pst = 0;
   logic        rdy, err, drv, pul, irq, dev, eev, nrg;
   int          n_errors = 0, num_checks = 0, pulses = 0;
   always #10 clk = ~clk;
   energy_detect_power_control #(.IDLE_CYCLES(50)) dut (
      .sys_clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
      .paddr_i(pa), .pwdata_i(pwd), .pstrb_i(pst), .prdata_o(prd), .pready_o(rdy),
      .pslverr_o(err), .data_event_i(dev), .error_event_i(eev), .energy_sensed_i(nrg),
      .line_driver_on_o(drv), .pulse_o(pul), .energy_sense_irq_o(irq));
   link_partner lp (.clk_i(clk), .data_o(dev), .err_o(eev), .energy_o(nrg));
   always @(posedge clk) if (pul === 1'b1) pulses++;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      pst <= 4'hf;
      @(posedge clk);
      pen <= 1'b1;
      // values read right after the edge are those the edge sampled
      do begin
         @(posedge clk);
         t++;
      end while (rdy !== 1'b1 && t < 20);
      if (rdy !== 1'b1) begin
         n_errors++;
         $display("[ERR] %0t no pready", $time);
      end
      rd = prd;
      re = err;
      psel <= 1'b0;
      pen <= 1'b0;
      @(negedge clk);
   endtask : apb
   task automatic wdrv(input logic v);
      int t;
      t = 0;
      while (drv !== v && t < 100) begin
         @(negedge clk);
         t++;
      end
      chk({31'h0, drv}, {31'h0, v});
   endtask : wdrv
   task automatic final_report;
      if (n_errors == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report
   initial begin
      repeat (3000) @(posedge clk);
      n_errors++;
      final_report();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      apb(0, 12'h074, 0);
      chk(rd, 32'h6411);
      apb(0, 12'h100, 0);
      chk({re, rd[30:0]}, 32'h80000000);
      apb(1, 12'h084, 1);
      apb(1, 12'h074, 32'he023);
      wdrv(0);
      apb(0, 12'h074, 0);
      chk(rd, 32'he023);
      chk({31'h0, irq}, 1);
      apb(0, 12'h080, 0);
      chk(rd, 1);
      apb(1, 12'h088, 1);
      chk({31'h0, irq}, 0);
      lp.sense(1);
      lp.send(0, 2);
      repeat (60) @(negedge clk);
      lp.send(0, 2);
      repeat (5) @(negedge clk);
      chk({31'h0, drv}, 0);
      pulses = 0;
      lp.send(0, 1);
      wdrv(1);
      repeat (20) @(negedge clk);
      chk(pulses, 4);
      apb(0, 12'h074, 0);
      chk(rd, 32'he523);
      apb(0, 12'h074, 0);
      chk(rd, 32'he423);
      apb(1, 12'h084, 0);
      chk({31'h0, irq}, 0);
      apb(0, 12'h080, 0);
      chk(rd, 1);
      apb(1, 12'h088, 1);
      apb(1, 12'h084, 1);
      lp.send(1, 2);
      apb(0, 12'h074, 0);
      chk(rd, 32'he623);
      chk({31'h0, drv}, 1);
      repeat (60) @(negedge clk);
      apb(0, 12'h074, 0);
      pulses = 0;
      apb(1, 12'h074, 32'hf823);
      wdrv(0);
      apb(0, 12'h074, 0);
      chk(rd, 32'he823);
      apb(1, 12'h074, 32'hf823);
      wdrv(1);
      repeat (20) @(negedge clk);
      chk(pulses, 1);
      apb(1, 12'h074, 32'hf823);
      wdrv(0);
      apb(1, 12'h074, 32'h6011);
      wdrv(1);
      final_report();
   end
endmodule : tb_energy_detect_power_control
